// >>> core/txdb_debug_packer.sv
// transmit link debug vector packer with AXI4-Lite control
`include "txdb_params.svh"

module txdb_debug_packer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire txdb_pkg::txdb_lane_in_t lane_in [`TXDB_NUM_LANES],
  input wire txdb_pkg::txdb_ctrl_in_t ctrl_in,
  input wire txdb_pkg::txdb_aux_in_t aux_in,
  output txdb_pkg::txdb_lane_vec_t lane_debug [`TXDB_NUM_LANES],
  output txdb_pkg::txdb_ctrl_vec_t ctrl_debug,
  output txdb_pkg::txdb_aux_vec_t aux_debug,
  output logic aux_tick_1mhz
);
  import txdb_pkg::*;

  localparam logic [7:0] TICK_LAST = 8'(`TXDB_AUX_TICK_CYCLES - 1);

  logic [1:0] ctrl_reg;
  logic capture_en;
  logic narrow_mode;
  logic [7:0] tick_cnt_reg;
  logic tick_reg;
  logic [31:0] tick_total_reg;
  txdb_lane_vec_t lane_vec_reg [`TXDB_NUM_LANES];
  txdb_ctrl_vec_t ctrl_vec_reg;
  txdb_aux_vec_t aux_vec_reg;

  logic aw_held_reg;
  logic [7:0] awaddr_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_commit;
  logic [31:0] status_word;

  assign capture_en = ctrl_reg[`TXDB_CTRL_CAPTURE_BIT];
  assign narrow_mode = ctrl_reg[`TXDB_CTRL_NARROW_BIT];
  assign wr_commit = aw_held_reg & w_held_reg & ~bvalid_reg;

  // 1 MHz timing tick for the aux line coder; exact only when the bus
  // clock is an integer multiple of 1 MHz, which the integrator guarantees
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
      tick_total_reg <= 32'h0000_0000;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= 8'h00;
      tick_reg <= 1'b1;
      tick_total_reg <= tick_total_reg + 32'h0000_0001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // per-lane transceiver vectors; narrow mode zeroes the unused upper lanes of the data, control and disparity fields
  generate
    for (genvar i = 0; i < `TXDB_NUM_LANES; i++) begin : g_lane
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lane_vec_reg[i] <= '0;
        end else if (capture_en) begin
          lane_vec_reg[i][31:16] <= narrow_mode ? 16'h0000 : lane_in[i].data_word[31:16];
          lane_vec_reg[i][15:0] <= lane_in[i].data_word[15:0];
          lane_vec_reg[i][35:34] <= narrow_mode ? 2'h0 : lane_in[i].control_char[3:2];
          lane_vec_reg[i][33:32] <= lane_in[i].control_char[1:0];
          lane_vec_reg[i][39:38] <= narrow_mode ? 2'h0 : lane_in[i].disparity_override[3:2];
          lane_vec_reg[i][37:36] <= lane_in[i].disparity_override[1:0];
          lane_vec_reg[i][44:40] <= lane_in[i].postcursor_level;
          lane_vec_reg[i][49:45] <= lane_in[i].precursor_level;
          lane_vec_reg[i][52:50] <= lane_in[i].swing_level;
          lane_vec_reg[i][54:53] <= lane_in[i].buffer_status;
          lane_vec_reg[i][55] <= 1'b0;
          lane_vec_reg[i][56] <= lane_in[i].pll_locked;
          lane_vec_reg[i][68:57] <= 12'h000;
        end
      end
      assign lane_debug[i] = lane_vec_reg[i];
    end
  endgenerate

  // link control vector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_vec_reg <= '0;
    end else if (capture_en) begin
      ctrl_vec_reg[0] <= ctrl_in.channel_pll_reset;
      ctrl_vec_reg[1] <= ctrl_in.cmd_channel_pll_reset;
      ctrl_vec_reg[2] <= ctrl_in.cmd_tx_reset;
      ctrl_vec_reg[4:3] <= ctrl_in.lanes01_reset_complete;
      ctrl_vec_reg[6:5] <= ctrl_in.lanes23_reset_complete;
      ctrl_vec_reg[7] <= ctrl_in.rate_2g7_selected;
      ctrl_vec_reg[8] <= ctrl_in.rate_5g4_selected;
      ctrl_vec_reg[9] <= ctrl_in.rate_1g62_selected;
      ctrl_vec_reg[14:10] <= ctrl_in.cfgport_state;
      ctrl_vec_reg[15] <= ctrl_in.cfgport_enable;
      ctrl_vec_reg[16] <= ctrl_in.cfgport_write;
      ctrl_vec_reg[32:17] <= ctrl_in.cfgport_read_data;
      ctrl_vec_reg[48:33] <= ctrl_in.cfgport_write_data;
      ctrl_vec_reg[52:49] <= ctrl_in.cfgport_rdy;
      ctrl_vec_reg[60:53] <= ctrl_in.cfgport_addr;
      ctrl_vec_reg[63:61] <= ctrl_in.tx_pattern_select;
      ctrl_vec_reg[67:64] <= ctrl_in.tx_power_down;
      ctrl_vec_reg[71:68] <= ctrl_in.tx_analog_reset_done;
      ctrl_vec_reg[72] <= ctrl_in.shared_pll_locked;
      ctrl_vec_reg[95:73] <= 23'h00_0000;
    end
  end

  // aux vector, bit order follows the struct from bit 0 upward
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_vec_reg <= 4'h0;
    end else if (capture_en) begin
      aux_vec_reg[0] <= aux_in.aux_rx_data;
      aux_vec_reg[1] <= aux_in.aux_tx_data;
      aux_vec_reg[2] <= aux_in.aux_out_enable_n;
      aux_vec_reg[3] <= aux_in.hot_plug_level;
    end
  end

  // status of the live inputs beside the captured aux vector, so software can compare
  assign status_word = {16'h0000, aux_vec_reg,
                        ctrl_in.shared_pll_locked,
                        lane_in[3].pll_locked, lane_in[2].pll_locked,
                        lane_in[1].pll_locked, lane_in[0].pll_locked,
                        ctrl_in.rate_1g62_selected, ctrl_in.rate_5g4_selected,
                        ctrl_in.rate_2g7_selected,
                        ctrl_in.lanes23_reset_complete, ctrl_in.lanes01_reset_complete};

  // write address and data are held separately so either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      awready_reg <= 1'b1;
    end else if (s_axi_awvalid && awready_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
      awready_reg <= 1'b0;
    end else if (wr_commit) begin
      aw_held_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      wready_reg <= 1'b1;
    end else if (s_axi_wvalid && wready_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      wready_reg <= 1'b0;
    end else if (wr_commit) begin
      w_held_reg <= 1'b0;
    end else if (bvalid_reg && s_axi_bready) begin
      wready_reg <= 1'b1;
    end
  end

  // register commit and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TXDB_CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TXDB_RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_reg <= 1'b1;
      if (awaddr_reg[7:2] == `TXDB_OFS_CTRL >> 2) begin
        bresp_reg <= `TXDB_RESP_OKAY;
        if (wstrb_reg[0]) begin
          ctrl_reg <= wdata_reg[1:0];
        end
      end else if (awaddr_reg[7:2] == `TXDB_OFS_STATUS >> 2 ||
                   awaddr_reg[7:2] == `TXDB_OFS_TICKS >> 2) begin
        bresp_reg <= `TXDB_RESP_OKAY;
      end else begin
        bresp_reg <= `TXDB_RESP_SLVERR;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `TXDB_RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= `TXDB_RESP_OKAY;
      case (s_axi_araddr[7:2])
        `TXDB_OFS_CTRL >> 2: rdata_reg <= {30'h0000_0000, ctrl_reg};
        `TXDB_OFS_STATUS >> 2: rdata_reg <= status_word;
        `TXDB_OFS_TICKS >> 2: rdata_reg <= tick_total_reg;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `TXDB_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ctrl_debug = ctrl_vec_reg;
  assign aux_debug = aux_vec_reg;
  assign aux_tick_1mhz = tick_reg;
endmodule : txdb_debug_packer

// >>> core/txdb_params.svh
// offsets, field positions, reset values and timing counts of the debug packer
`ifndef TXDB_PARAMS_SVH
`define TXDB_PARAMS_SVH
`define TXDB_CLK_PERIOD_NS 10
`define TXDB_AUX_TICK_NS 1000
`define TXDB_AUX_TICK_CYCLES (`TXDB_AUX_TICK_NS / `TXDB_CLK_PERIOD_NS)
`define TXDB_OFS_CTRL 8'h00
`define TXDB_OFS_STATUS 8'h04
`define TXDB_OFS_TICKS 8'h08
`define TXDB_CTRL_CAPTURE_BIT 0
`define TXDB_CTRL_NARROW_BIT 1
`define TXDB_CTRL_RESET 2'h1
`define TXDB_NUM_LANES 4
`define TXDB_LANE_VEC_W 69
`define TXDB_CTRL_VEC_W 96
`define TXDB_AUX_VEC_W 4
`define TXDB_RESP_OKAY 2'h0
`define TXDB_RESP_SLVERR 2'h2
`endif

// >>> core/txdb_pkg.sv
// types of the transmit link debug packer
package txdb_pkg;
  typedef struct packed {
    logic pll_locked;
    logic [1:0] buffer_status;
    logic [2:0] swing_level;
    logic [4:0] precursor_level;
    logic [4:0] postcursor_level;
    logic [3:0] disparity_override;
    logic [3:0] control_char;
    logic [31:0] data_word;
  } txdb_lane_in_t;

  typedef struct packed {
    logic shared_pll_locked;
    logic [3:0] tx_analog_reset_done;
    logic [3:0] tx_power_down;
    logic [2:0] tx_pattern_select;
    logic [7:0] cfgport_addr;
    logic [3:0] cfgport_rdy;
    logic [15:0] cfgport_write_data;
    logic [15:0] cfgport_read_data;
    logic cfgport_write;
    logic cfgport_enable;
    logic [4:0] cfgport_state;
    logic rate_1g62_selected;
    logic rate_5g4_selected;
    logic rate_2g7_selected;
    logic [1:0] lanes23_reset_complete;
    logic [1:0] lanes01_reset_complete;
    logic cmd_tx_reset;
    logic cmd_channel_pll_reset;
    logic channel_pll_reset;
  } txdb_ctrl_in_t;

  typedef struct packed {
    logic hot_plug_level;
    logic aux_out_enable_n;
    logic aux_tx_data;
    logic aux_rx_data;
  } txdb_aux_in_t;

  typedef logic [68:0] txdb_lane_vec_t;
  typedef logic [95:0] txdb_ctrl_vec_t;
  typedef logic [3:0] txdb_aux_vec_t;
endpackage : txdb_pkg

// >>> sim/txdb_debug_packer_chk.sv
// assertion checker for the transmit link debug packer
`include "txdb_params.svh"
module txdb_debug_packer_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire txdb_pkg::txdb_lane_in_t lane_in [`TXDB_NUM_LANES],
  input wire txdb_pkg::txdb_ctrl_in_t ctrl_in,
  input wire txdb_pkg::txdb_aux_in_t aux_in,
  input wire txdb_pkg::txdb_lane_vec_t lane_debug [`TXDB_NUM_LANES],
  input wire txdb_pkg::txdb_ctrl_vec_t ctrl_debug,
  input wire txdb_pkg::txdb_aux_vec_t aux_debug,
  input wire logic aux_tick_1mhz
);
  timeunit 1ns;
  timeprecision 1ps;
  import txdb_pkg::*;
  logic [7:0] gap_reg;
  logic seen_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // saturates so a dead tick still shows as a gap overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_reg <= 8'h00;
      seen_reg <= 1'h0;
    end else if (aux_tick_1mhz) begin
      gap_reg <= 8'h00;
      seen_reg <= 1'h1;
    end else if (gap_reg != 8'hFF) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end
  // narrow mode may clear upper halves, so only the always-live bits are tied
  for (genvar g = 0; g < `TXDB_NUM_LANES; g++) begin : g_lane
    sequence s_lane_moved;
      lane_debug[g] != $past(lane_debug[g]);
    endsequence
    property p_lane_low;
      s_lane_moved |-> lane_debug[g][15:0] == $past(lane_in[g][15:0])
        && lane_debug[g][33:32] == $past(lane_in[g][33:32])
        && lane_debug[g][37:36] == $past(lane_in[g][37:36]);
    endproperty
    a_lane_low: assert property (p_lane_low) else $error("lane low bits wrong");
    property p_lane_drive;
      s_lane_moved |-> lane_debug[g][54:40] == $past(lane_in[g][54:40])
        && lane_debug[g][56] == $past(lane_in[g][55]);
    endproperty
    a_lane_drive: assert property (p_lane_drive) else $error("lane drive bits wrong");
    property p_lane_rsvd;
      lane_debug[g][55] == 1'h0 && lane_debug[g][68:57] == 12'h000;
    endproperty
    a_lane_rsvd: assert property (p_lane_rsvd) else $error("lane spare bits set");
  end
  sequence s_ctrl_moved;
    ctrl_debug != $past(ctrl_debug);
  endsequence
  property p_ctrl_status;
    s_ctrl_moved |-> ctrl_debug[9:0] == $past(ctrl_in[9:0]);
  endproperty
  a_ctrl_status: assert property (p_ctrl_status) else $error("ctrl low bits wrong");
  property p_ctrl_port;
    s_ctrl_moved |-> ctrl_debug[72:10] == $past(ctrl_in[72:10]);
  endproperty
  a_ctrl_port: assert property (p_ctrl_port) else $error("ctrl port bits wrong");
  property p_ctrl_rsvd;
    ctrl_debug[95:73] == 23'h000000;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("ctrl spare bits set");
  property p_aux;
    aux_debug != $past(aux_debug) |-> aux_debug == $past(aux_in);
  endproperty
  a_aux: assert property (p_aux) else $error("aux vector wrong");
  property p_tick_period;
    seen_reg && aux_tick_1mhz |-> gap_reg == 8'h63;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick too early");
  property p_tick_bound;
    seen_reg |-> gap_reg <= 8'h63;
  endproperty
  a_tick_bound: assert property (p_tick_bound) else $error("tick missing");
endmodule : txdb_debug_packer_chk

bind txdb_debug_packer txdb_debug_packer_chk i_chk (.aclk, .aresetn, .lane_in, .ctrl_in, .aux_in,
  .lane_debug, .ctrl_debug, .aux_debug, .aux_tick_1mhz);

// >>> sim/txdb_la_model.sv
// single-sample logic analyzer standing at the control debug vector
module txdb_la_model (
  input wire logic aclk,
  input wire logic trig,
  input wire txdb_pkg::txdb_ctrl_vec_t ctrl_vec,
  output txdb_pkg::txdb_ctrl_vec_t ctrl_snap
);
  timeunit 1ns;
  timeprecision 1ps;
  import txdb_pkg::*;
  always_ff @(posedge aclk) begin
    if (trig) begin
      ctrl_snap <= ctrl_vec;
    end
  end
endmodule : txdb_la_model

// >>> sim/tb.sv
// testbench of the transmit link debug packer
`include "txdb_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import txdb_pkg::*;
  typedef struct packed {
    logic [55:0] ln;
    logic [72:0] ct;
    logic [3:0] ax;
    logic [3:0] ex_ax;
  } txdb_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, aux_tick_1mhz;
  logic trig;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, t0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  txdb_lane_in_t lane_in [`TXDB_NUM_LANES];
  txdb_ctrl_in_t ctrl_in;
  txdb_aux_in_t aux_in;
  txdb_lane_vec_t lane_debug [`TXDB_NUM_LANES];
  txdb_ctrl_vec_t ctrl_debug, ctrl_snap;
  txdb_aux_vec_t aux_debug;
  int fail_count = 0;
  int n_compared = 0;
  int k;
  txdb_row_t rows [4] = '{
    '{56'hFF_FFFF_FFFF_FFFF, 73'h1FF_FFFF_FFFF_FFFF_FFFF, 4'hF, 4'hF},
    '{56'hA5_A5A5_A5A5_A5A5, 73'h0A5_A5A5_A5A5_A5A5_A5A5, 4'h5, 4'h5},
    '{56'h5A_5A5A_5A5A_5A5A, 73'h15A_5A5A_5A5A_5A5A_5A5A, 4'hA, 4'hA},
    '{56'h80_0000_0000_0001, 73'h100_0000_0000_0000_0001, 4'h8, 4'h8}};

  txdb_debug_packer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .lane_in, .ctrl_in, .aux_in, .lane_debug, .ctrl_debug,
    .aux_debug, .aux_tick_1mhz);
  txdb_la_model i_la (.aclk, .trig, .ctrl_vec(ctrl_debug), .ctrl_snap);

  // 100 MHz keeps the aux tick an exact divide of the bus clock
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50 && !s_axi_bvalid; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 50) begin
      fail_count++;
      end_sim();
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50 && !s_axi_rvalid; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n == 50) begin
      fail_count++;
      end_sim();
    end
  endtask : axi_read

  function automatic logic [68:0] exp_lane(input logic [55:0] v, input logic nar);
    logic [68:0] e;
    e = {12'h000, v[55], 1'h0, v[54:0]};
    if (nar) begin
      e[31:16] = 16'h0000;
      e[35:34] = 2'h0;
      e[39:38] = 2'h0;
    end
    return e;
  endfunction : exp_lane

  // lanes get distinct words so a swapped lane shows up
  task automatic apply(input logic [55:0] ln, input logic [72:0] ct, input logic [3:0] ax);
    @(posedge aclk);
    for (int i = 0; i < `TXDB_NUM_LANES; i++) lane_in[i] <= ln ^ 56'(i);
    ctrl_in <= ct;
    aux_in <= ax;
    @(posedge aclk);
    #1;
  endtask : apply

  task automatic check_vecs(input logic [55:0] ln, input logic [72:0] ct, input logic [3:0] ax,
    input logic nar);
    for (int i = 0; i < `TXDB_NUM_LANES; i++) begin
      chk("lane", 96'(exp_lane(ln ^ 56'(i), nar)), 96'(lane_debug[i]));
    end
    chk("ctrl", {23'h000000, ct}, ctrl_debug);
    chk("aux", 96'(ax), 96'(aux_debug));
  endtask : check_vecs

  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, trig} = 6'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    ctrl_in = '0;
    aux_in = '0;
    lane_in = '{default: '0};
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(`TXDB_OFS_CTRL, rd, rs);
    chk("ctrl reg", 96'h1, 96'(rd));
    axi_read(8'h0C, rd, rs);
    chk("unmapped resp", 96'(`TXDB_RESP_SLVERR), 96'(rs));
    chk("unmapped data", 96'h0, 96'(rd));
    foreach (rows[i]) begin
      apply(rows[i].ln, rows[i].ct, rows[i].ax);
      check_vecs(rows[i].ln, rows[i].ct, rows[i].ex_ax, 1'h0);
    end
    axi_write(`TXDB_OFS_CTRL, 32'h3, rs);
    chk("ctrl write resp", 96'(`TXDB_RESP_OKAY), 96'(rs));
    apply(rows[0].ln, rows[0].ct, rows[0].ax);
    check_vecs(rows[0].ln, rows[0].ct, rows[0].ex_ax, 1'h1);
    // capture off: the vectors must hold the last sample
    axi_write(`TXDB_OFS_CTRL, 32'h0, rs);
    apply(rows[1].ln, rows[1].ct, rows[1].ax);
    check_vecs(rows[0].ln, rows[0].ct, rows[0].ex_ax, 1'h1);
    @(posedge aclk);
    trig <= 1'h1;
    @(posedge aclk);
    trig <= 1'h0;
    @(posedge aclk);
    #1;
    chk("snapshot", {23'h000000, rows[0].ct}, ctrl_snap);
    // status is live: frozen aux vector beside the current inputs
    axi_read(`TXDB_OFS_STATUS, rd, rs);
    chk("status", 96'({16'h0000, rows[0].ax, rows[1].ct[72], {4{rows[1].ln[55]}},
      rows[1].ct[9:3]}), 96'(rd));
    axi_write(`TXDB_OFS_STATUS, 32'hFFFF_FFFF, rs);
    chk("status write resp", 96'(`TXDB_RESP_OKAY), 96'(rs));
    axi_write(8'h0C, 32'h0, rs);
    chk("unmapped write resp", 96'(`TXDB_RESP_SLVERR), 96'(rs));
    for (k = 0; k < 200 && !aux_tick_1mhz; k++) @(posedge aclk);
    if (k == 200) fail_count++;
    @(posedge aclk);
    for (k = 1; k < 200 && !aux_tick_1mhz; k++) @(posedge aclk);
    if (k == 200) fail_count++;
    chk("tick gap", 96'h64, 96'(k));
    // reads land 2 and 205 cycles after a tick, so two ticks fall between
    axi_read(`TXDB_OFS_TICKS, t0, rs);
    repeat (200) @(posedge aclk);
    axi_read(`TXDB_OFS_TICKS, rd, rs);
    chk("tick count", 96'h2, 96'(rd - t0));
    end_sim();
  end
endmodule : tb
